//--- include/fcim_pkg.sv
// Purpose: Constants shared by the fault-code input monitor.
// Assumes: 100 MHz system clock.
// Notes: Fault codes are major.minor; the index is major*100+minor.
package fcim_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SIMUL_TIME_S = 3;
  localparam int PAIR_TIME_MS = 500;
  localparam int CFG_TIME_S = 3600;
  localparam longint SIMUL_CYC = longint'(SIMUL_TIME_S) * CLK_HZ;
  localparam longint PAIR_CYC = longint'(PAIR_TIME_MS) * (CLK_HZ / 1000);
  localparam longint CFG_CYC = longint'(CFG_TIME_S) * CLK_HZ;
  localparam int TMR_W = 40;
  localparam int NUM_IN = 4;
  localparam int NUM_MOD = 8;
  localparam int NUM_TERM = 16;
  localparam int NUM_OUT = 8;
  localparam int IDX_SCALE = 100;

  typedef enum logic [2:0] {
    FCIM_DUAL = 3'b000,
    FCIM_COMPL = 3'b001,
    FCIM_DCOMP = 3'b010,
    FCIM_NONE = 3'b111
  } fcim_itype_t;

  // Major and minor parts of each fault code.
  localparam logic [7:0] MJ_OUT = 8'h01;
  localparam logic [7:0] MJ_IN = 8'h02;
  localparam logic [7:0] MJ_SYS = 8'h04;
  localparam logic [7:0] MN_SEQ = 8'h0a;
  localparam logic [7:0] MN_CONC = 8'h01;
  localparam logic [7:0] MN_SIMUL = 8'h02;
  localparam logic [7:0] MN_PCONC_A = 8'h03;
  localparam logic [7:0] MN_PSIM_A = 8'h04;
  localparam logic [7:0] MN_PCONC_B = 8'h05;
  localparam logic [7:0] MN_PSIM_B = 8'h06;
  localparam logic [7:0] MN_CFG_KEY = 8'h0c;
  localparam logic [7:0] MN_CFG_SW = 8'h0d;
  localparam logic [7:0] MN_OTEMP = 8'h23;
  localparam logic [7:0] MN_OLINK_A = 8'h28;
  localparam logic [7:0] MN_OLINK_B = 8'h29;
  localparam logic [7:0] MN_MISM = 8'h2a;
  localparam logic [7:0] MN_XLINK = 8'h2b;
  localparam logic [7:0] MN_STRAY = 8'h30;
  localparam logic [7:0] MN_DISP = 8'h38;
  localparam logic [7:0] MN_SHORT = 8'h3c;
  localparam logic [7:0] MN_UNSUP = 8'h3d;
  localparam logic [15:0] IDX_NONE = 16'h0000;
endpackage : fcim_pkg

//--- design/fcim_pair_mon.sv
// Purpose: Concurrency and simultaneity checks on one pair of run levels.
// Assumes: Inputs are synchronised run levels on clk.
// Notes: Sticky flags clear only on reset.
`timescale 1ns/1ps
module fcim_pair_mon #(
  parameter logic [39:0] LIMIT = 40'h0000000001
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Run levels
  input wire logic en,
  input wire logic run_a,
  input wire logic run_b,
  // Sticky faults
  output logic conc,
  output logic simul
);
  logic both_run;
  logic armed;
  logic [39:0] tmr;
  wire one_run = en && (run_a ^ run_b);
  wire both_now = run_a && run_b;
  wire both_stop = !run_a && !run_b;
  wire tmr_end = one_run && (tmr >= LIMIT - 40'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      both_run <= 1'b0;
      armed <= 1'b0;
      conc <= 1'b0;
    end else begin
      if (both_now && !armed) both_run <= 1'b1;
      else if (both_stop) both_run <= 1'b0;
      if (en && both_run && one_run) armed <= 1'b1;
      else if (both_stop) armed <= 1'b0;
      if (en && armed && both_now) conc <= 1'b1;
      if (armed && both_now) armed <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr <= 40'h0;
      simul <= 1'b0;
    end else begin
      tmr <= (one_run && !both_run) ? tmr + 40'h1 : 40'h0;
      if (tmr_end && !both_run) simul <= 1'b1;
    end
  end
endmodule : fcim_pair_mon

//--- design/fcim_top.sv
// Purpose: Fault detection and fault-code index reporting for safety inputs.
// Assumes: Field pins are asynchronous and pass two flip-flops first.
// Notes: First fault found is latched; later faults set flags only.
`timescale 1ns/1ps
module fcim_top
  import fcim_pkg::*;
#(
  parameter longint SIMUL_LIMIT = SIMUL_CYC,
  parameter longint PAIR_LIMIT = PAIR_CYC,
  parameter longint CFG_LIMIT = CFG_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Safety input pins, two channels or pairs per input
  input wire logic [fcim_pkg::NUM_IN-1:0] in_a,
  input wire logic [fcim_pkg::NUM_IN-1:0] in_b,
  input wire logic [fcim_pkg::NUM_IN-1:0] in_c,
  input wire logic [fcim_pkg::NUM_IN-1:0] in_d,
  input wire logic [3*fcim_pkg::NUM_IN-1:0] in_type,
  // System sense pins
  input wire logic seq_err,
  input wire logic [1:0] out_link_lost,
  input wire logic xm_link_lost,
  input wire logic [fcim_pkg::NUM_MOD-1:0] mod_found,
  input wire logic [fcim_pkg::NUM_MOD-1:0] mod_expect,
  input wire logic [fcim_pkg::NUM_TERM-1:0] term_volt,
  input wire logic [fcim_pkg::NUM_TERM-1:0] term_used,
  input wire logic [fcim_pkg::NUM_OUT-1:0] out_short,
  input wire logic over_temp,
  input wire logic disp_fail,
  input wire logic cfg_unsup,
  input wire logic cfg_mode,
  input wire logic key_act,
  input wire logic sw_cmd,
  // Fault report
  output logic [15:0] fault_index,
  output logic [7:0] fault_major,
  output logic [7:0] fault_minor,
  output logic fault_active,
  output logic [fcim_pkg::NUM_OUT-1:0] short_detail,
  output logic cfg_confirmed,
  output logic run_allow
);
  import fcim_pkg::*;

  localparam int NPIN = 4 * NUM_IN + 4 + NUM_MOD * 2 + NUM_TERM * 2 + NUM_OUT + 7;

  function automatic logic [15:0] make_index(input logic [7:0] mj, input logic [7:0] mn);
    make_index = 16'(mj * IDX_SCALE) + 16'(mn);
  endfunction : make_index

  function automatic logic [TMR_W-1:0] next_count(input logic [TMR_W-1:0] c);
    next_count = (c == {TMR_W{1'b1}}) ? c : c + 1'b1;
  endfunction : next_count

  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  wire [NPIN-1:0] pin_raw = {in_a, in_b, in_c, in_d, seq_err, out_link_lost, xm_link_lost,
    mod_found, mod_expect, term_volt, term_used, out_short, over_temp, disp_fail,
    cfg_unsup, cfg_mode, key_act, sw_cmd, 1'b0};

  // Two flip-flops before any logic reads a pin other than in_type, which is read directly.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  logic [NUM_IN-1:0] sa, sb, sc, sd;
  logic s_seq, s_xm, s_ot, s_disp, s_uns, s_cfg, s_key, s_sw, s_spare;
  logic [1:0] s_olink;
  logic [NUM_MOD-1:0] s_mf, s_me;
  logic [NUM_TERM-1:0] s_tv, s_tu;
  logic [NUM_OUT-1:0] s_sh;
  assign {sa, sb, sc, sd, s_seq, s_olink, s_xm, s_mf, s_me, s_tv, s_tu, s_sh, s_ot, s_disp,
    s_uns, s_cfg, s_key, s_sw, s_spare} = pin_s2;

  // Per-input monitors: channel level and pair level.
  logic [NUM_IN-1:0] conc_ch, sim_ch, conc_pa, sim_pa, conc_pb, sim_pb;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      wire [2:0] ty = in_type[3*gi +: 3];
      wire dcomp = (ty == FCIM_DCOMP);
      wire chan = (ty == FCIM_DUAL) || (ty == FCIM_COMPL);
      // Complementary members: run when a high and b low (pair A), c high and d low (pair B).
      wire pa_run = sa[gi] && !sb[gi];
      wire pb_run = sc[gi] && !sd[gi];
      wire ch_a = sa[gi];
      wire ch_b = (ty == FCIM_COMPL) ? !sb[gi] : sb[gi];
      fcim_pair_mon #(.LIMIT(TMR_W'(SIMUL_LIMIT))) u_outer (
        .clk(clk), .rst_n(rst_n), .en(chan || dcomp),
        .run_a(dcomp ? pa_run : ch_a), .run_b(dcomp ? pb_run : ch_b),
        .conc(conc_ch[gi]), .simul(sim_ch[gi]));
      fcim_pair_mon #(.LIMIT(TMR_W'(PAIR_LIMIT))) u_pa (
        .clk(clk), .rst_n(rst_n), .en(dcomp), .run_a(sa[gi]), .run_b(!sb[gi]),
        .conc(conc_pa[gi]), .simul(sim_pa[gi]));
      fcim_pair_mon #(.LIMIT(TMR_W'(PAIR_LIMIT))) u_pb (
        .clk(clk), .rst_n(rst_n), .en(dcomp), .run_a(sc[gi]), .run_b(!sd[gi]),
        .conc(conc_pb[gi]), .simul(sim_pb[gi]));
    end
  endgenerate

  logic [TMR_W-1:0] key_tmr;
  logic [TMR_W-1:0] sw_tmr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_tmr <= '0;
      sw_tmr <= '0;
    end else begin
      key_tmr <= (!s_cfg || s_key) ? '0 : next_count(key_tmr);
      sw_tmr <= (!s_cfg || s_sw) ? '0 : next_count(sw_tmr);
    end
  end
  wire cfg_key_to = (key_tmr >= TMR_W'(CFG_LIMIT));
  wire cfg_sw_to = (sw_tmr >= TMR_W'(CFG_LIMIT));

  // Fault detection, highest priority first; code picked by continuous selection.
  wire f_mism = (s_mf != s_me);
  wire f_stray = |(s_tv & ~s_tu);
  wire f_short = |s_sh;
  logic hit;
  logic [7:0] sel_mj;
  logic [7:0] sel_mn;
  // Major and minor kept as separate fields.
  always_comb begin
    hit = 1'b1;
    sel_mj = MJ_SYS;
    sel_mn = 8'h00;
    if (s_seq) begin sel_mj = MJ_OUT; sel_mn = MN_SEQ; end
    else if (|conc_ch) begin sel_mj = MJ_IN; sel_mn = MN_CONC; end
    else if (|sim_ch) begin sel_mj = MJ_IN; sel_mn = MN_SIMUL; end
    else if (|conc_pa) begin sel_mj = MJ_IN; sel_mn = MN_PCONC_A; end
    else if (|conc_pb) begin sel_mj = MJ_IN; sel_mn = MN_PCONC_B; end
    else if (|sim_pa) begin sel_mj = MJ_IN; sel_mn = MN_PSIM_A; end
    else if (|sim_pb) begin sel_mj = MJ_IN; sel_mn = MN_PSIM_B; end
    else if (s_ot) sel_mn = MN_OTEMP;
    else if (s_olink[0]) sel_mn = MN_OLINK_A;
    else if (s_olink[1]) sel_mn = MN_OLINK_B;
    else if (s_xm) sel_mn = MN_XLINK;
    else if (f_mism) sel_mn = MN_MISM;
    else if (f_stray) sel_mn = MN_STRAY;
    else if (s_disp) sel_mn = MN_DISP;
    else if (f_short) sel_mn = MN_SHORT;
    else if (s_uns) sel_mn = MN_UNSUP;
    else if (cfg_key_to) sel_mn = MN_CFG_KEY;
    else if (cfg_sw_to) sel_mn = MN_CFG_SW;
    else hit = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_active <= 1'b0;
      fault_major <= 8'h00;
      fault_minor <= 8'h00;
      fault_index <= IDX_NONE;
    end else if (hit && !fault_active) begin
      fault_active <= 1'b1;
      fault_major <= sel_mj;
      fault_minor <= sel_mn;
      // Whole code in one 16-bit value.
      fault_index <= make_index(sel_mj, sel_mn);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      short_detail <= '0;
      cfg_confirmed <= 1'b0;
      run_allow <= 1'b0;
    end else begin
      short_detail <= short_detail | s_sh;
      if (s_uns) cfg_confirmed <= 1'b1;
      run_allow <= !(hit || fault_active || s_uns);
    end
  end

  // The spare synchroniser bit keeps the pin vector aligned and is otherwise unused.
  wire unused_ok = s_spare;
endmodule : fcim_top

//--- verif/fcim_props.sv
// Purpose: Port-level checks on the fault-code input monitor.
// Assumes: One clock domain, reset active low.
// Notes: Pins pass a two-stage synchroniser, so causes need three samples.
`timescale 1ns/1ps
module fcim_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sense pins
  input wire logic seq_err,
  input wire logic over_temp,
  input wire logic disp_fail,
  input wire logic cfg_unsup,
  input wire logic [7:0] out_short,
  // Report
  input wire logic [15:0] fault_index,
  input wire logic [7:0] fault_major,
  input wire logic [7:0] fault_minor,
  input wire logic fault_active,
  input wire logic [7:0] short_detail,
  input wire logic cfg_confirmed,
  input wire logic run_allow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PACK: assert property (fault_active |-> fault_index == 16'(fault_major) * 16'h0064 + 16'(fault_minor))
    else $error("index does not match major and minor");
  AST_NONE: assert property (!fault_active |-> fault_index == 16'h0000)
    else $error("index set with no fault");
  AST_HOLD: assert property (fault_active |=> fault_active && $stable(fault_index))
    else $error("latched code changed");
  AST_SEQ: assert property (seq_err [*3] ##0 !fault_active |=> fault_index == 16'h006e)
    else $error("sequence error not reported");
  AST_OTEMP: assert property (over_temp [*4] |=> fault_active && !run_allow)
    else $error("overtemperature not latched");
  AST_DISP: assert property (disp_fail [*4] |=> fault_active)
    else $error("display failure not latched");
  AST_SHORT: assert property (out_short[0] [*3] |=> short_detail[0])
    else $error("short detail missing");
  AST_UNSUP: assert property (cfg_unsup [*4] |=> cfg_confirmed && !run_allow)
    else $error("unsupported config allowed to run");
endmodule : fcim_props

//--- verif/fcim_field.sv
// Purpose: Two-channel field device feeding one safety input.
// Assumes: Levels change on the falling edge only.
// Notes: Complementary wiring inverts the second channel.
`timescale 1ns/1ps
module fcim_field #(
  parameter bit COMPL = 1'b0
) (
  // Clock and requested run states
  input wire logic clk,
  input wire logic go_a,
  input wire logic go_b,
  // Channel levels
  output logic ch_a,
  output logic ch_b
);
  logic req_a = 1'b0;
  logic req_b = 1'b0;
  initial ch_a = 1'b0;
  initial ch_b = COMPL;
  // Requests are taken on the rising edge, so the levels never race the bench at the falling edge.
  always @(posedge clk) begin
    req_a <= go_a;
    req_b <= go_b;
  end
  always @(negedge clk) begin
    ch_a <= req_a;
    ch_b <= COMPL ? !req_b : req_b;
  end
endmodule : fcim_field

//--- verif/fcim_top_test.sv
// Purpose: Self-checking bench for the fault-code input monitor.
// Assumes: Short time limits set through parameters.
// Notes: Each fault case starts from a fresh reset since the first code wins.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module fcim_top_test;
  import fcim_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [1:0] go_a = 2'h0, go_b = 2'h0;
  wire [1:0] fa, fb;
  logic [3:0] pin_c = 4'h0, pin_d = 4'h0;
  logic [11:0] in_type = 12'hfc8;
  logic seq_err = 1'b0, xm_link_lost = 1'b0, over_temp = 1'b0, disp_fail = 1'b0, cfg_unsup = 1'b0;
  logic cfg_mode = 1'b0, key_act = 1'b0, sw_cmd = 1'b0;
  logic [1:0] out_link_lost = 2'h0;
  logic [7:0] mod_found = 8'h0f, out_short = 8'h00, short_detail, fault_major, fault_minor;
  logic [15:0] term_volt = 16'h0000, fault_index;
  logic fault_active, cfg_confirmed, run_allow;
  int n_mismatch = 0, check_count = 0;
  // Rows: one sense pin each, then the code it should latch.
  logic [25:0] rows [10] = '{{10'h200, 16'h006e}, {10'h100, 16'h01b9}, {10'h080, 16'h01b8},
    {10'h040, 16'h01bb}, {10'h020, 16'h01ba}, {10'h010, 16'h01c0}, {10'h008, 16'h01cc},
    {10'h004, 16'h01b3}, {10'h002, 16'h01c8}, {10'h001, 16'h01cd}};
  always #5 clk = ~clk;
  // Input 0 is wired straight, input 1 complementary.
  fcim_field i_fcim_field (.clk(clk), .go_a(go_a[0]), .go_b(go_b[0]), .ch_a(fa[0]), .ch_b(fb[0]));
  fcim_field #(.COMPL(1'b1)) i_fcim_field_cpl (.clk(clk), .go_a(go_a[1]), .go_b(go_b[1]),
    .ch_a(fa[1]), .ch_b(fb[1]));
  fcim_top #(.SIMUL_LIMIT(20), .PAIR_LIMIT(10), .CFG_LIMIT(30)) i_fcim_top (.clk(clk), .rst_n(rst_n),
    .in_a({2'h0, fa}), .in_b({2'h0, fb}), .in_c(pin_c), .in_d(pin_d), .in_type(in_type),
    .seq_err(seq_err), .out_link_lost(out_link_lost), .xm_link_lost(xm_link_lost),
    .mod_found(mod_found), .mod_expect(8'h0f), .term_volt(term_volt), .term_used(16'hfffe),
    .out_short(out_short), .over_temp(over_temp), .disp_fail(disp_fail), .cfg_unsup(cfg_unsup),
    .cfg_mode(cfg_mode), .key_act(key_act), .sw_cmd(sw_cmd), .fault_index(fault_index),
    .fault_major(fault_major), .fault_minor(fault_minor), .fault_active(fault_active),
    .short_detail(short_detail), .cfg_confirmed(cfg_confirmed), .run_allow(run_allow));
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  task automatic apply(input logic [9:0] s);
    seq_err = s[9];
    out_link_lost = s[8:7];
    xm_link_lost = s[6];
    mod_found = 8'h0f ^ {7'h00, s[5]};
    term_volt = {15'h0000, s[4]};
    out_short = {7'h00, s[3]};
    over_temp = s[2];
    disp_fail = s[1];
    cfg_unsup = s[0];
  endtask : apply
  // Type word and input 0 levels {a, b, c, d} settle while reset is held.
  task automatic restart(input logic [11:0] ty, input logic [3:0] lv);
    apply(10'h000);
    in_type = ty;
    go_a = {1'b0, lv[3]};
    go_b = {1'b0, lv[2]};
    pin_c = {3'h0, lv[1]};
    pin_d = {3'h0, lv[0]};
    {cfg_mode, key_act} = 2'h0;
    rst_n = 1'b0;
    wait_n(6);
    rst_n = 1'b1;
    wait_n(4);
    `CHK(run_allow, 1'b1)
  endtask : restart
  task automatic close_out();
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial begin
    #(5000 * 10);
    n_mismatch++;
    close_out();
  end
  initial begin
    @(negedge clk);
    foreach (rows[k]) begin
      restart(12'hfc8, 4'h0);
      apply(rows[k][25:16]);
      wait_n(5);
      `CHK(fault_index, rows[k][15:0])
      `CHK(short_detail, {7'h00, rows[k][19]})
      `CHK(cfg_confirmed, rows[k][16])
    end
    // All pins at once: the sequence error wins and stays after the pins clear.
    restart(12'hfc8, 4'h0);
    apply(10'h3ff);
    wait_n(5);
    apply(10'h000);
    wait_n(10);
    `CHK(fault_index, 16'h006e)
    // One channel drops out of run and returns.
    restart(12'hfc8, 4'h0);
    go_a = 2'h1;
    go_b = 2'h1;
    wait_n(5);
    go_b = 2'h0;
    wait_n(3);
    go_b = 2'h1;
    wait_n(5);
    `CHK(fault_index, 16'h00c9)
    // The same on the complementary input.
    restart(12'hfc8, 4'h0);
    go_a = 2'h2;
    go_b = 2'h2;
    wait_n(5);
    go_b = 2'h0;
    wait_n(3);
    go_b = 2'h2;
    wait_n(5);
    `CHK(fault_index, 16'h00c9)
    // Second channel never follows; limit is 20 cycles.
    restart(12'hfc8, 4'h0);
    go_a = 2'h1;
    wait_n(10);
    `CHK(fault_index, 16'h0000)
    wait_n(20);
    `CHK(fault_index, 16'h00ca)
    // Dual-complementary input 0: one member of pair A runs alone past the 10-cycle pair limit.
    restart(12'hfca, 4'h5);
    go_a = 2'h1;
    wait_n(8);
    `CHK(fault_index, 16'h0000)
    wait_n(12);
    `CHK(fault_index, 16'h00cc)
    // Both pairs run, pair B drops out and returns; the input-level code MN_CONC has priority over MN_PCONC_B.
    restart(12'hfca, 4'ha);
    pin_d = 4'h1;
    wait_n(3);
    pin_d = 4'h0;
    wait_n(5);
    `CHK(fault_index, 16'h00c9)
    // Pair A runs alone; its member b drops out and returns well inside the outer window.
    restart(12'hfca, 4'h9);
    go_b = 2'h1;
    wait_n(3);
    go_b = 2'h0;
    wait_n(5);
    `CHK(fault_index, 16'h00cb)
    // Pair A runs alone and pair B never follows.
    restart(12'hfca, 4'h9);
    wait_n(25);
    `CHK(fault_index, 16'h00ca)
    // Keypad busy, software silent: only the software idle timer runs out.
    restart(12'hfc8, 4'h0);
    {cfg_mode, key_act} = 2'h3;
    wait_n(20);
    `CHK(fault_index, 16'h0000)
    wait_n(25);
    `CHK(fault_index, 16'h019d)
    close_out();
  end
endmodule : fcim_top_test
bind fcim_top fcim_props i_fcim_props (.clk(clk), .rst_n(rst_n), .seq_err(seq_err),
  .over_temp(over_temp), .disp_fail(disp_fail), .cfg_unsup(cfg_unsup), .out_short(out_short),
  .fault_index(fault_index), .fault_major(fault_major), .fault_minor(fault_minor),
  .fault_active(fault_active), .short_detail(short_detail), .cfg_confirmed(cfg_confirmed),
  .run_allow(run_allow));
